//--- hdl/mode_sel_pkg.sv
// Constants and types for the operation mode selector
package mode_sel_pkg;
  localparam int unsigned CHANNELS = 8;
  localparam int unsigned DIAG_WIDTH = 16;
  localparam int unsigned STATE_WIDTH = 8;
  localparam int unsigned DIAG_DISC_BIT = 0;
  localparam logic [15:0] DIAG_RESET = 16'h0000;
  localparam logic [7:0] CODE_UNDEF = 8'h00;
  localparam logic [7:0] CODE_RUN = 8'h01;
  localparam logic [7:0] CODE_STOP = 8'h02;
  localparam logic [7:0] CODE_SAFE = 8'h03;
  localparam logic [7:0] CODE_ERROR = 8'h04;
  localparam logic [7:0] CODE_RESET = 8'h05;
  localparam logic [7:0] CODE_START = 8'h06;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned DISC_TIME_MS = 150;
  localparam int unsigned DISC_CYCLES = DISC_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned DISC_CNT_W = 24;
  // Arbitrary neutral identifier value
  localparam logic [15:0] BLOCK_ID = 16'h0a01;

  typedef enum logic [2:0] {
    ST_STOP = 3'b000,
    ST_SAFE = 3'b001,
    ST_START = 3'b011,
    ST_RUN = 3'b010,
    ST_ERROR = 3'b110,
    ST_RESET = 3'b111
  } sel_state_t;
endpackage : mode_sel_pkg

//--- hdl/input_sync.sv
// Two-stage synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // Per-bit two-flop chain; first stage read only by second
  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        meta_reg[b] <= 1'b0;
        sync_reg[b] <= 1'b0;
      end else begin
        meta_reg[b] <= async_i[b];
        sync_reg[b] <= meta_reg[b];
      end
    end
  end

  assign sync_o = sync_reg;
endmodule : input_sync
`default_nettype wire

//--- hdl/operation_mode_selector.sv
// Safety operation mode selector with discrepancy supervision
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Error output high while a monitoring fault stands, low otherwise.
// - Keep a 16-bit diagnostic word; bit 0 flags discrepancy error.
// - Report state as 8-bit code; 0 undefined, 1 to 6 states.
// - RUN code 1 with one input set: outputs copy inputs, error low.
// - Run enable low outside ERROR gives STOP code 2, outputs low, error low.
// - None or several inputs set gives SAFE code 3, outputs low.
// - Fault gives ERROR code 4, error high, outputs low, report diag.
// - Fault gone and acknowledge high gives RESET code 5, outputs low.
// - Restart enabled and high gives START code 6; wait falling edge.
// - Map options copy state and diag to process image each cycle.
// - With restart, outputs stay safe until low-high-low restart, no timeout.
// - On restart fall recheck single input; enable only outside error.
// - A mode change with several inputs set is supervised by a discrepancy time.
module operation_mode_selector
  import mode_sel_pkg::*;
#(
  parameter int unsigned DISC_LIMIT = DISC_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic block_run_enable_i,
  input wire logic group_fault_acknowledge_i,
  input wire logic restart_enable_i,
  input wire logic restart_i,
  input wire logic map_state_i,
  input wire logic map_diag_i,
  input wire logic [mode_sel_pkg::CHANNELS-1:0] mode_select_in_i,
  output logic [mode_sel_pkg::CHANNELS-1:0] mode_enable_out_o,
  output logic error_o,
  output logic diag_event_o,
  output logic [mode_sel_pkg::DIAG_WIDTH-1:0] diagnostic_word_o,
  output logic [mode_sel_pkg::STATE_WIDTH-1:0] state_code_o,
  output logic [mode_sel_pkg::DIAG_WIDTH-1:0] image_diag_o,
  output logic [mode_sel_pkg::STATE_WIDTH-1:0] image_state_o
);
  import mode_sel_pkg::*;

  logic [CHANNELS+3:0] raw_in;
  logic [CHANNELS+3:0] sync_in;
  logic [CHANNELS-1:0] sel;
  logic run_en;
  logic ack;
  logic rst_en;
  logic rst_in;
  logic one_hot;
  logic any_sel;

  // Restart enable is a static configuration, synchronised with the rest
  assign raw_in = {restart_enable_i, restart_i, group_fault_acknowledge_i, block_run_enable_i, mode_select_in_i};

  input_sync #(
    .WIDTH(CHANNELS + 4)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(raw_in),
    .sync_o(sync_in)
  );

  assign sel = sync_in[CHANNELS-1:0];
  assign run_en = sync_in[CHANNELS];
  assign ack = sync_in[CHANNELS+1];
  assign rst_in = sync_in[CHANNELS+2];
  assign rst_en = sync_in[CHANNELS+3];
  assign one_hot = (sel != '0) && ((sel & (sel - 1'b1)) == '0);
  assign any_sel = (sel != '0);

  sel_state_t state_reg, state_next;
  logic [DISC_CNT_W-1:0] disc_cnt_reg, disc_cnt_next;
  logic [CHANNELS-1:0] prev_sel_reg, prev_sel_next;
  logic restart_prev_reg, restart_prev_next;
  logic armed_reg, armed_next;
  logic [DIAG_WIDTH-1:0] diag_reg, diag_next;
  logic [CHANNELS-1:0] out_reg, out_next;
  logic err_reg, err_next;
  logic evt_reg, evt_next;
  logic [STATE_WIDTH-1:0] code_reg, code_next;
  logic [DIAG_WIDTH-1:0] img_diag_reg, img_diag_next;
  logic [STATE_WIDTH-1:0] img_state_reg, img_state_next;
  logic disc_expired;
  logic restart_fall;

  assign disc_expired = (disc_cnt_reg >= DISC_LIMIT[DISC_CNT_W-1:0]);
  assign restart_fall = restart_prev_reg && !rst_in;

  always_comb begin
    state_next = state_reg;
    disc_cnt_next = disc_cnt_reg;
    prev_sel_next = sel;
    restart_prev_next = rst_in;
    // Restart held since enable must be released before a press counts
    armed_next = armed_reg || !rst_in;
    diag_next = diag_reg;
    evt_next = 1'b0;
    // Discrepancy timer runs while no single mode is established
    if (one_hot || !run_en) begin
      disc_cnt_next = '0;
    end else if (!disc_expired) begin
      disc_cnt_next = disc_cnt_reg + 1'b1;
    end
    unique case (state_reg)
      ST_STOP: begin
        armed_next = 1'b0;
        if (run_en) begin
          state_next = ST_SAFE;
        end
      end
      ST_SAFE: begin
        // Only fault with several inputs set, not with inputs idle
        if (disc_expired && any_sel && !one_hot) begin
          state_next = ST_ERROR;
          diag_next[DIAG_DISC_BIT] = 1'b1;
          evt_next = 1'b1;
        end else if (one_hot && !rst_en) begin
          state_next = ST_RUN;
        end else if (one_hot && rst_in && armed_reg) begin
          state_next = ST_START;
          armed_next = 1'b1;
        end
      end
      ST_START: begin
        // No timeout here: waits for restart release indefinitely
        if (restart_fall) begin
          if (one_hot) begin
            state_next = ST_RUN;
          end else begin
            state_next = ST_SAFE;
          end
          armed_next = 1'b0;
        end else if (!one_hot && !rst_in) begin
          state_next = ST_SAFE;
        end
      end
      ST_RUN: begin
        if (!one_hot || sel != prev_sel_reg) begin
          state_next = ST_SAFE;
        end
      end
      ST_ERROR: begin
        // Fault stays latched until the group acknowledges it
        if (ack && !(any_sel && !one_hot)) begin
          state_next = ST_RESET;
          diag_next = DIAG_RESET;
        end
      end
      ST_RESET: begin
        if (!ack) begin
          state_next = ST_SAFE;
        end
      end
    endcase
    // Run enable low overrides, but an unacknowledged fault survives
    if (!run_en && state_reg != ST_ERROR) begin
      state_next = ST_STOP;
    end
  end

  always_comb begin
    out_next = '0;
    err_next = 1'b0;
    code_next = CODE_UNDEF;
    unique case (state_next)
      ST_RUN: begin
        out_next = sel;
        code_next = CODE_RUN;
      end
      ST_STOP: code_next = CODE_STOP;
      ST_SAFE: code_next = CODE_SAFE;
      ST_START: code_next = CODE_START;
      ST_ERROR: begin
        err_next = 1'b1;
        code_next = CODE_ERROR;
      end
      ST_RESET: code_next = CODE_RESET;
    endcase
    img_state_next = map_state_i ? code_next : '0;
    img_diag_next = map_diag_i ? diag_next : '0;
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_STOP;
      disc_cnt_reg <= '0;
      prev_sel_reg <= '0;
      restart_prev_reg <= 1'b0;
      armed_reg <= 1'b0;
      diag_reg <= DIAG_RESET;
      out_reg <= '0;
      err_reg <= 1'b0;
      evt_reg <= 1'b0;
      code_reg <= CODE_STOP;
      img_diag_reg <= '0;
      img_state_reg <= '0;
    end else begin
      state_reg <= state_next;
      disc_cnt_reg <= disc_cnt_next;
      prev_sel_reg <= prev_sel_next;
      restart_prev_reg <= restart_prev_next;
      armed_reg <= armed_next;
      diag_reg <= diag_next;
      out_reg <= out_next;
      err_reg <= err_next;
      evt_reg <= evt_next;
      code_reg <= code_next;
      img_diag_reg <= img_diag_next;
      img_state_reg <= img_state_next;
    end
  end

  assign mode_enable_out_o = out_reg;
  assign error_o = err_reg;
  assign diag_event_o = evt_reg;
  assign diagnostic_word_o = diag_reg;
  assign state_code_o = code_reg;
  assign image_diag_o = img_diag_reg;
  assign image_state_o = img_state_reg;
endmodule : operation_mode_selector
`default_nettype wire

//--- tb/group_model.sv
// Group module model that acknowledges faults
`timescale 1ns/1ps
`default_nettype none
module group_model #(parameter int DELAY = 2) (
  input wire logic sys_clk_i,
  input wire logic fault_i,
  input wire logic grant_i,
  output logic ack_o
);
  int cnt = 0;
  initial ack_o = 1'b0;
  // Ack only once the fault has stood a while and the operator agrees
  always @(posedge sys_clk_i) begin
    cnt <= ((fault_i || ack_o) && grant_i) ? cnt + 1 : 0;
    ack_o <= grant_i && cnt >= DELAY;
  end
endmodule : group_model
`default_nettype wire

//--- tb/operation_mode_selector_assertions.sv
// Port checker for the operation mode selector
`timescale 1ns/1ps
`default_nettype none
module mode_sel_checker
  import mode_sel_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic block_run_enable_i,
  input wire logic map_state_i,
  input wire logic map_diag_i,
  input wire logic [mode_sel_pkg::CHANNELS-1:0] mode_enable_out_o,
  input wire logic error_o,
  input wire logic diag_event_o,
  input wire logic [mode_sel_pkg::DIAG_WIDTH-1:0] diagnostic_word_o,
  input wire logic [mode_sel_pkg::STATE_WIDTH-1:0] state_code_o,
  input wire logic [mode_sel_pkg::DIAG_WIDTH-1:0] image_diag_o,
  input wire logic [mode_sel_pkg::STATE_WIDTH-1:0] image_state_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_err; error_o == (state_code_o == CODE_ERROR); endproperty
  a_err: assert property (p_err) else $error("error flag off state");
  property p_code; state_code_o inside {[CODE_RUN:CODE_START]}; endproperty
  a_code: assert property (p_code) else $error("state code out of range");
  property p_idle; state_code_o != CODE_RUN |-> mode_enable_out_o == '0; endproperty
  a_idle: assert property (p_idle) else $error("output outside run");
  property p_run; state_code_o == CODE_RUN |-> $onehot(mode_enable_out_o) && !error_o; endproperty
  a_run: assert property (p_run) else $error("run outputs not single");
  property p_stop;
    $fell(block_run_enable_i) && state_code_o != CODE_ERROR |-> ##[1:4] state_code_o == CODE_STOP;
  endproperty
  a_stop: assert property (p_stop) else $error("no stop after run low");
  property p_dbit; error_o |-> diagnostic_word_o == 16'h0001; endproperty
  a_dbit: assert property (p_dbit) else $error("diag word wrong in error");
  property p_evt; $rose(error_o) |-> ##[0:1] diag_event_o; endproperty
  a_evt: assert property (p_evt) else $error("no diag message on fault");
  property p_ist; map_state_i [*2] ##0 $stable(state_code_o) |-> image_state_o == state_code_o; endproperty
  a_ist: assert property (p_ist) else $error("state image stale");
  property p_idg; !map_diag_i [*2] |-> image_diag_o == '0; endproperty
  a_idg: assert property (p_idg) else $error("diag image not cleared");
endmodule : mode_sel_checker
bind operation_mode_selector mode_sel_checker u_mode_sel_checker (.sys_clk_i, .sys_rst_i,
  .block_run_enable_i, .map_state_i, .map_diag_i, .mode_enable_out_o, .error_o, .diag_event_o,
  .diagnostic_word_o, .state_code_o, .image_diag_o, .image_state_o);
`default_nettype wire

//--- tb/operation_mode_selector_tb.sv
// Self-checking bench for the operation mode selector
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module operation_mode_selector_tb;
  import mode_sel_pkg::*;
  localparam int LIM = 20;
  logic sys_clk_i = 0, sys_rst_i = 1, run = 0, ack, rs_en = 0, rs = 0, m_st = 1, m_dg = 1, grant = 0, err, evt;
  logic [7:0] sel = '0, outs, st, ist, lf = 8'h0e;
  logic [15:0] dw, idw;
  int n_errors = 0, n_checks = 0, n_evt = 0;
  operation_mode_selector #(.DISC_LIMIT(LIM)) u_operation_mode_selector (.sys_clk_i, .sys_rst_i,
    .block_run_enable_i(run), .group_fault_acknowledge_i(ack), .restart_enable_i(rs_en), .restart_i(rs),
    .map_state_i(m_st), .map_diag_i(m_dg), .mode_select_in_i(sel), .mode_enable_out_o(outs), .error_o(err),
    .diag_event_o(evt), .diagnostic_word_o(dw), .state_code_o(st), .image_diag_o(idw), .image_state_o(ist));
  group_model u_group_model (.sys_clk_i, .fault_i(err), .grant_i(grant), .ack_o(ack));
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  // Count fault messages away from the launching edge
  always @(negedge sys_clk_i) begin
    if (evt === 1'b1) begin
      n_evt++;
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  // Steady state expected for a plain selection, restart off
  function automatic int model(input logic [7:0] s);
    return !run ? 2 : ($onehot(s) ? 1 : 3);
  endfunction : model
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #2;
  endtask : cyc
  // Settle time covers two sync stages plus state hops
  task automatic check(input int code, input logic [7:0] eo);
    cyc(8);
    `CHK(st, 8'(code))
    `CHK(outs, eo)
    `CHK(err, logic'(code == 4))
    `CHK(dw, 16'(code == 4))
    `CHK(ist, m_st ? 8'(code) : 8'h00)
    `CHK(idw, m_dg ? 16'(code == 4) : 16'h0000)
  endtask : check
  task automatic close_out();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    #100000;
    n_errors++;
    close_out();
  end
  initial begin
    cyc(6);
    sys_rst_i = 0;
    check(2, 8'h00);
    run = 1;
    cyc(LIM);
    check(3, 8'h00);
    for (int i = 0; i < 16; i++) begin
      lf = lfsr(lf);
      sel = i < 8 ? 8'h01 << i : (lf[3] ? 8'h00 : 8'h01 << lf[2:0]);
      check(model(sel), model(sel) == 1 ? sel : 8'h00);
    end
    sel = 8'h81;
    cyc(LIM + 4);
    check(4, 8'h00);
    run = 0;
    check(4, 8'h00);
    `CHK(n_evt, 1)
    sel = 8'h00;
    run = 1;
    grant = 1;
    check(5, 8'h00);
    grant = 0;
    check(3, 8'h00);
    rs_en = 1;
    rs = 1;
    sel = 8'h01;
    check(6, 8'h00);
    rs = 0;
    check(1, 8'h01);
    sel = 8'h02;
    check(3, 8'h00);
    rs = 1;
    check(6, 8'h00);
    rs = 0;
    check(1, 8'h02);
    m_st = 0;
    m_dg = 0;
    run = 0;
    check(2, 8'h00);
    rs = 1;
    sel = 8'h04;
    run = 1;
    check(3, 8'h00);
    rs = 0;
    check(3, 8'h00);
    rs = 1;
    check(6, 8'h00);
    rs = 0;
    check(1, 8'h04);
    close_out();
  end
endmodule : operation_mode_selector_tb
`default_nettype wire
